// ==== src/command_error_reporter.sv ====
`timescale 1ns/1ps
`include "error_report_map.svh"
// Functional notes
// RULE1 - Settable, queryable flag enables error messages.
// RULE2 - Send prefix plus three-digit decimal code.
// RULE3 - Unknown name 001, bad syntax 002.
// RULE4 - Locked parameter change refused, code 004.
// RULE5 - Wrong unlock password gives 005, lock stays.
// RULE6 - DSP resource overflow refused, code 060.
// RULE7 - Executing empty macro or preset: 070.
// RULE8 - Factory preset write or delete refused.
// RULE9 - Preset check reports failed stored commands.
// RULE10 - Append to full 256-command macro refused.
// RULE11 - Illegal stored macro or input action errors.
// RULE12 - Storage writes blocked while password locked.
// RULE13 - Out of space discards current macro only.
// RULE14 - Macro command outside session is error.
// RULE15 - Bus hardware handshake failure reported distinctly.
// RULE16 - Bus software handshake failure reported separately.
// RULE17 - Conflicting unit identifier on bus reported.
// RULE18 - Factory preset violation uses code 071.
// RULE19 - Disabled: detect and refuse, send nothing.
module command_error_reporter
  import error_report_pkg::*;
(
  input  wire logic       clock_i,              // 25 MHz clock.
  input  wire logic       rst_b_i,              // Async reset, low.
  input  wire logic       cmd_valid_i,          // Parsed command strobe.
  input  wire logic       name_known_i,         // Command name matched.
  input  wire logic       syntax_ok_i,          // Arguments well formed.
  input  wire logic       changes_param_i,      // Command alters a param.
  input  wire logic       param_locked_i,       // Target param is locked.
  input  wire logic       unlock_req_i,         // Unlock attempt.
  input  wire logic       password_ok_i,        // Password matched.
  input  wire logic       dsp_over_i,           // Would exceed DSP budget.
  input  wire logic       exec_macro_i,         // Macro/preset run request.
  input  wire logic       target_empty_i,       // Named macro is empty.
  input  wire logic       preset_write_i,       // Preset store or delete.
  input  wire logic       factory_preset_i,     // Target is factory preset.
  input  wire logic       preset_check_i,       // Preset check request.
  input  wire logic       preset_failed_i,      // Stored command failed.
  input  wire logic       stored_illegal_i,     // Stored command illegal.
  input  wire logic       writes_storage_i,     // Writes non-volatile.
  input  wire logic       storage_write_lock_i, // Storage password lock.
  input  wire logic       storage_full_i,       // No space left.
  input  wire logic [2:0] cmd_kind_i,           // cmd_kind_t of command.
  input  wire logic       set_enable_i,         // Write reporting flag.
  input  wire logic       enable_value_i,       // Value to write.
  input  wire logic       hw_handshake_fail_i,  // Bus pin, async.
  input  wire logic       sw_handshake_fail_i,  // Bus protocol event.
  input  wire logic       unit_id_conflict_i,   // Bus ID clash event.
  input  wire logic       char_ready_i,         // Serial sink takes char.
  output logic            report_enable_o,      // Reporting flag state.
  output logic            cmd_accept_o,         // Command may execute.
  output logic            cmd_reject_o,         // Command refused.
  output logic [9:0]      error_code_o,         // Last detected code.
  output logic            macro_session_o,      // Macro session open.
  output logic [8:0]      macro_count_o,        // Commands in macro.
  output logic            macro_discard_o,      // Current macro dropped.
  output logic            char_valid_o,         // Message char valid.
  output logic [7:0]      char_o                // Message ASCII char.
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Digit extraction is called from one place, once per message digit.
  function automatic logic [7:0] digit_char(input logic [9:0] v,
                                            input logic [1:0] pos);
    logic [9:0] d;
    d = 10'd0;
    case (pos)
      2'd0:    d = v / 10'd100;
      2'd1:    d = (v / 10'd10) % 10'd10;
      default: d = v % 10'd10;
    endcase
    digit_char = 8'h30 + {4'h0, d[3:0]};
  endfunction

  // Fixed prefix characters of the unsolicited message.
  // Any unit tag in front of the prefix is added further downstream.
  // The prefix spells the word ERROR followed by a hash sign.
  function automatic logic [7:0] prefix_char(input logic [2:0] idx);
    case (idx)
      3'd0:    prefix_char = 8'h45;
      3'd1:    prefix_char = 8'h52;
      3'd2:    prefix_char = 8'h52;
      3'd3:    prefix_char = 8'h4F;
      3'd4:    prefix_char = 8'h52;
      default: prefix_char = 8'h23;
    endcase
  endfunction

  // --------------------------------------------------------------------
  // Bus pin synchroniser
  // --------------------------------------------------------------------
  logic [2:0] hw_sync_reg;
  logic       hw_level_reg;
  logic       hw_event;

  // Three stages; a change counts once stages two and three agree.
  // Stage one may still be settling, so it never feeds any decision.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hw_sync_reg  <= 3'h0;
      hw_level_reg <= 1'b0;
    end else begin
      hw_sync_reg <= {hw_sync_reg[1:0], hw_handshake_fail_i};
      if (hw_sync_reg[1] == hw_sync_reg[2]) begin
        hw_level_reg <= hw_sync_reg[2];
      end
    end
  end

  // A rising, agreed level is one failure event.
  assign hw_event = (hw_sync_reg[1] == hw_sync_reg[2]) &&
                    hw_sync_reg[2] && !hw_level_reg;

  // --------------------------------------------------------------------
  // Command classification
  // --------------------------------------------------------------------
  logic       in_session;
  logic       cmd_err;
  logic [9:0] cmd_code;
  logic [9:0] evt_code;
  logic       evt_err;

  // The session flag is the registered one, so a begin followed by an
  // append works, but nothing inside one command can open a session
  // for itself.
  assign in_session = macro_session_o;

  // First match in priority order names the single code reported.
  // The password check sits above the lock check so that a failed unlock
  // names the password and not the lock it could not open.
  always_comb begin
    cmd_err  = 1'b1;
    cmd_code = 10'd0;
    if (!name_known_i) begin
      cmd_code = `ERR_CODE_UNKNOWN_CMD;                 // see RULE3
    end else if (!syntax_ok_i) begin
      cmd_code = `ERR_CODE_SYNTAX;                      // see RULE3
    end else if (unlock_req_i && !password_ok_i) begin
      cmd_code = `ERR_CODE_BAD_PASSWORD;                // see RULE5
    end else if (changes_param_i && param_locked_i) begin
      cmd_code = `ERR_CODE_LOCKED;                      // see RULE4
    end else if (preset_write_i && factory_preset_i) begin
      cmd_code = `ERR_CODE_FACTORY_PRESET;              // see RULE8 RULE18
    end else if (writes_storage_i && storage_write_lock_i) begin
      cmd_code = `ERR_CODE_STORAGE_LOCKED;              // see RULE12
    end else if (cmd_kind_i == 3'(CMD_MACRO_APPEND) && !in_session) begin
      cmd_code = `ERR_CODE_NO_SESSION;                  // see RULE14
    end else if (stored_illegal_i) begin
      cmd_code = `ERR_CODE_ILLEGAL_STORED;              // see RULE11
    end else if (cmd_kind_i == 3'(CMD_MACRO_APPEND) &&
                 macro_count_o == `MACRO_LIMIT) begin
      cmd_code = `ERR_CODE_MACRO_FULL;                  // see RULE10
    end else if (cmd_kind_i == 3'(CMD_MACRO_APPEND) && storage_full_i) begin
      cmd_code = `ERR_CODE_STORAGE_FULL;                // see RULE13
    end else if (dsp_over_i) begin
      cmd_code = `ERR_CODE_DSP_OVERFLOW;                // see RULE6
    end else if (exec_macro_i && target_empty_i) begin
      cmd_code = `ERR_CODE_EMPTY_MACRO;                 // see RULE7
    end else if (preset_check_i && preset_failed_i) begin
      cmd_code = `ERR_CODE_PRESET_CHECK;                // see RULE9
    end else begin
      cmd_err = 1'b0;
    end
  end

  // Bus events; hardware handshake outranks the other two.
  always_comb begin
    evt_err  = 1'b1;
    evt_code = 10'd0;
    if (hw_event) begin
      evt_code = `ERR_CODE_HW_HANDSHAKE;                // see RULE15
    end else if (sw_handshake_fail_i) begin
      evt_code = `ERR_CODE_SW_HANDSHAKE;                // see RULE16
    end else if (unit_id_conflict_i) begin
      evt_code = `ERR_CODE_UNIT_ID;                     // see RULE17
    end else begin
      evt_err = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Reporting flag
  // --------------------------------------------------------------------
  // A refused command never changes the flag, so a malformed request
  // leaves reporting as it was.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      report_enable_o <= `ENABLE_RESET_VALUE;
    end else if (cmd_valid_i && set_enable_i && !cmd_err) begin
      report_enable_o <= enable_value_i;                // see RULE1
    end
  end

  // --------------------------------------------------------------------
  // Verdict outputs
  // --------------------------------------------------------------------
  // Refusal happens regardless of the flag; only the message depends on it.
  // The code register keeps the last error until a newer one replaces
  // it; accepted commands leave it untouched.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_accept_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      error_code_o <= 10'd0;
    end else begin
      cmd_accept_o <= cmd_valid_i && !cmd_err;
      cmd_reject_o <= cmd_valid_i && cmd_err;           // see RULE19
      if (cmd_valid_i && cmd_err) begin
        error_code_o <= cmd_code;
      end else if (evt_err) begin
        error_code_o <= evt_code;
      end
    end
  end

  // --------------------------------------------------------------------
  // Macro session tracking
  // --------------------------------------------------------------------
  logic upload_reg;

  // A storage overflow drops only the macro in progress; earlier
  // macros of an upload have already been committed and survive.
  // A second begin restarts the count and abandons the half-built macro.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      macro_session_o <= 1'b0;
      macro_count_o   <= 9'd0;
      macro_discard_o <= 1'b0;
      upload_reg      <= 1'b0;
    end else begin
      macro_discard_o <= 1'b0;
      if (cmd_valid_i) begin
        if (cmd_code == `ERR_CODE_STORAGE_FULL && cmd_err) begin
          macro_session_o <= 1'b0;                      // see RULE13
          macro_count_o   <= 9'd0;
          macro_discard_o <= 1'b1;
          upload_reg      <= 1'b0;
        end else if (!cmd_err) begin
          case (cmd_kind_i)
            3'(CMD_MACRO_BEGIN): begin
              macro_session_o <= 1'b1;                  // see RULE14
              macro_count_o   <= 9'd0;
            end
            3'(CMD_UPLOAD_BEGIN): begin
              macro_session_o <= 1'b1;
              macro_count_o   <= 9'd0;
              upload_reg      <= 1'b1;
            end
            3'(CMD_MACRO_APPEND): begin
              macro_count_o <= macro_count_o + 9'd1;    // see RULE10
            end
            3'(CMD_MACRO_END): begin
              macro_count_o   <= 9'd0;
              macro_session_o <= upload_reg;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Message sequencer
  // --------------------------------------------------------------------
  msg_state_t state_reg;
  logic [3:0] idx_reg;
  logic [9:0] msg_code_reg;
  logic       pend_reg;
  logic [9:0] pend_code_reg;
  logic       new_err;
  logic [9:0] new_code;

  assign new_err  = (cmd_valid_i && cmd_err) || evt_err;
  assign new_code = (cmd_valid_i && cmd_err) ? cmd_code : evt_code;

  // One error may wait while a message is in flight; later ones are
  // dropped rather than stalling the command path.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg      <= 1'b0;
      pend_code_reg <= 10'd0;
    end else if (new_err && report_enable_o && !pend_reg) begin
      pend_reg      <= 1'b1;                            // see RULE19
      pend_code_reg <= new_code;
    end else if (state_reg == MSG_IDLE) begin
      pend_reg <= 1'b0;
    end
  end

  // Six prefix chars then three digits, each held until taken.
  // The wait cycle after the last digit keeps a gap between messages.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= MSG_IDLE;
      idx_reg      <= 4'h0;
      msg_code_reg <= 10'd0;
      char_valid_o <= 1'b0;
      char_o       <= 8'h00;
    end else begin
      case (state_reg)
        MSG_IDLE: begin
          if (pend_reg) begin
            msg_code_reg <= pend_code_reg;
            idx_reg      <= 4'h0;
            char_valid_o <= 1'b1;
            char_o       <= prefix_char(3'h0);          // see RULE2
            state_reg    <= MSG_SEND;
          end
        end
        MSG_SEND: begin
          if (char_ready_i) begin
            if (idx_reg == `MSG_LEN - 4'd1) begin
              char_valid_o <= 1'b0;
              state_reg    <= MSG_WAIT;
            end else begin
              idx_reg <= idx_reg + 4'd1;
              if (idx_reg + 4'd1 < {1'b0, `MSG_PREFIX_LEN}) begin
                char_o <= prefix_char(3'(idx_reg + 4'd1));
              end else begin
                char_o <= digit_char(msg_code_reg,      // see RULE2
                          2'(idx_reg + 4'd1 - {1'b0, `MSG_PREFIX_LEN}));
              end
            end
          end
        end
        MSG_WAIT: begin
          state_reg <= MSG_IDLE;
        end
        default: begin
          state_reg <= MSG_IDLE;
        end
      endcase
    end
  end

endmodule // command_error_reporter

// ==== src/error_report_map.svh ====
`ifndef ERROR_REPORT_MAP_SVH
`define ERROR_REPORT_MAP_SVH

// ----------------------------------------------------------------------
// Error codes, message framing and limits
// ----------------------------------------------------------------------
`define ERR_CODE_UNKNOWN_CMD     10'd1
`define ERR_CODE_SYNTAX          10'd2
`define ERR_CODE_LOCKED          10'd4
`define ERR_CODE_BAD_PASSWORD    10'd5
`define ERR_CODE_DSP_OVERFLOW    10'd60
`define ERR_CODE_EMPTY_MACRO     10'd70
`define ERR_CODE_FACTORY_PRESET  10'd71
`define ERR_CODE_PRESET_CHECK    10'd72
`define ERR_CODE_MACRO_FULL      10'd73
`define ERR_CODE_ILLEGAL_STORED  10'd74
`define ERR_CODE_STORAGE_LOCKED  10'd75
`define ERR_CODE_STORAGE_FULL    10'd76
`define ERR_CODE_NO_SESSION      10'd77
`define ERR_CODE_HW_HANDSHAKE    10'd78
`define ERR_CODE_SW_HANDSHAKE    10'd79
`define ERR_CODE_UNIT_ID         10'd80
`define MACRO_LIMIT              9'd256
`define ENABLE_RESET_VALUE       1'b1
`define MSG_PREFIX_LEN           3'd6
`define MSG_LEN                  4'd9

`endif

// ==== src/error_report_pkg.sv ====
package error_report_pkg;

  // Output message sequencer states.
  typedef enum logic [1:0] {
    MSG_IDLE,
    MSG_SEND,
    MSG_WAIT
  } msg_state_t;

  // Command kinds of one checked command.
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_MACRO_BEGIN,
    CMD_MACRO_APPEND,
    CMD_MACRO_END,
    CMD_UPLOAD_BEGIN,
    CMD_OTHER
  } cmd_kind_t;

endpackage

// ==== tb/command_error_reporter_asserts.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module command_error_reporter_asserts (
  input wire logic       clock_i,         // Clock.
  input wire logic       rst_b_i,         // Reset, low.
  input wire logic       cmd_valid_i,     // Command strobe.
  input wire logic       name_known_i,    // Name matched.
  input wire logic       syntax_ok_i,     // Syntax good.
  input wire logic       unlock_req_i,    // Unlock try.
  input wire logic       password_ok_i,   // Password good.
  input wire logic       char_ready_i,    // Sink ready.
  input wire logic       cmd_accept_o,    // Accepted.
  input wire logic       cmd_reject_o,    // Refused.
  input wire logic [9:0] error_code_o,    // Error code.
  input wire logic       report_enable_o, // Flag.
  input wire logic [8:0] macro_count_o,   // Macro size.
  input wire logic       macro_session_o, // Session open.
  input wire logic       macro_discard_o, // Macro dropped.
  input wire logic       char_valid_o,    // Char valid.
  input wire logic [7:0] char_o           // Char.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // Every command gets exactly one verdict, and only commands get one.
  property p_verdict; cmd_valid_i |=> cmd_accept_o != cmd_reject_o;
  endproperty
  a_verdict: assert property (p_verdict)
    else $error("verdict missing or doubled");
  property p_quiet; !cmd_valid_i |=> !cmd_accept_o && !cmd_reject_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("verdict without command");
  property p_unknown;
    cmd_valid_i && !name_known_i |=> cmd_reject_o && error_code_o == 10'd1;
  endproperty
  a_unknown: assert property (p_unknown)
    else $error("unknown name not coded 1");
  property p_syntax; cmd_valid_i && name_known_i && !syntax_ok_i
    |=> cmd_reject_o && error_code_o == 10'd2; endproperty
  a_syntax: assert property (p_syntax)
    else $error("bad syntax not coded 2");
  property p_passwd; cmd_valid_i && name_known_i && syntax_ok_i &&
    unlock_req_i && !password_ok_i |=> cmd_reject_o && error_code_o == 10'd5;
  endproperty
  a_passwd: assert property (p_passwd)
    else $error("wrong password not coded 5");
  // A stalled char must stay put, or the host would lose a digit.
  property p_hold; char_valid_o && !char_ready_i
    |=> char_valid_o && $stable(char_o); endproperty
  a_hold: assert property (p_hold)
    else $error("char dropped while stalled");
  property p_prefix; $rose(char_valid_o) |-> char_o == 8'h45; endproperty
  a_prefix: assert property (p_prefix)
    else $error("message does not start with E");
  // Three quiet disabled cycles leave nothing pending to send.
  property p_disabled; (!report_enable_o && !char_valid_o)[*3]
    |=> !char_valid_o; endproperty
  a_disabled: assert property (p_disabled)
    else $error("message sent while disabled");
  property p_limit; macro_count_o <= 9'h100; endproperty
  a_limit: assert property (p_limit)
    else $error("macro grew past its limit");
  property p_discard; macro_discard_o
    |-> !macro_session_o && macro_count_o == 9'h000; endproperty
  a_discard: assert property (p_discard)
    else $error("discard left macro open");

  c_message: cover property (cmd_reject_o ##1 char_valid_o);
  c_stall: cover property (char_valid_o && !char_ready_i);
  c_discard: cover property (macro_discard_o);
endmodule // command_error_reporter_asserts

bind command_error_reporter command_error_reporter_asserts
  u_command_error_reporter_asserts (.*);

// ==== tb/host_serial_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host sink
// ------------------------------------------------------------
module host_serial_model (
  input  wire logic        clock_i,      // Clock.
  input  wire logic        rst_b_i,      // Reset, low.
  input  wire logic        slow_i,       // Stall at times.
  input  wire logic        char_valid_i, // Char offered.
  input  wire logic [7:0]  char_i,       // Char value.
  output logic             char_ready_o, // Char taken.
  output logic [71:0]      msg_o,        // Last message.
  output int               msg_count_o   // Messages seen.
);
  logic [63:0] shift_reg;
  int          nchar_reg;

  // A slow host takes one cycle in three, so the sender has to hold.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      char_ready_o <= 1'b0;
    end else begin
      char_ready_o <= !slow_i || ($urandom % 3 == 0);
    end
  end

  // Nine taken chars make one message: prefix and three digits.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= '0;
      nchar_reg <= 0;
      msg_o <= '0;
      msg_count_o <= 0;
    end else if (char_valid_i && char_ready_o) begin
      shift_reg <= {shift_reg[55:0], char_i};
      if (nchar_reg == 8) begin
        msg_o <= {shift_reg, char_i};
        msg_count_o <= msg_count_o + 1;
        nchar_reg <= 0;
      end else begin
        nchar_reg <= nchar_reg + 1;
      end
    end
  end
endmodule // host_serial_model

// ==== tb/command_error_reporter_tb.sv ====
`timescale 1ns/1ps
module command_error_reporter_tb;
  localparam logic [21:0] BASE = 22'h310014;
  logic clock_i, rst_b_i, cmd_valid_i, slow, char_ready_i;
  logic name_known_i, syntax_ok_i, changes_param_i, param_locked_i;
  logic unlock_req_i, password_ok_i, dsp_over_i, exec_macro_i;
  logic target_empty_i, preset_write_i, factory_preset_i;
  logic preset_check_i, preset_failed_i, stored_illegal_i;
  logic writes_storage_i, storage_write_lock_i, storage_full_i;
  logic [2:0] cmd_kind_i;
  logic set_enable_i, enable_value_i, hw, sw, uid;
  logic report_enable_o, cmd_accept_o, cmd_reject_o, macro_session_o;
  logic macro_discard_o, char_valid_o;
  logic [9:0] error_code_o;
  logic [8:0] macro_count_o;
  logic [7:0] char_o;
  logic [71:0] msg;
  logic [21:0] q, f;
  logic [21:0] masks [11] = '{22'h200000, 22'h100000, 22'h030000,
    22'h0C0000, 22'h001800, 22'h0000C0, 22'h00001C, 22'h000100,
    22'h008000, 22'h006000, 22'h000600};
  int msgs, err_count, checks_done, cnt;
  logic en, sess, up;

  // One packed word carries every command qualifier.
  assign {name_known_i, syntax_ok_i, changes_param_i, param_locked_i,
    unlock_req_i, password_ok_i, dsp_over_i, exec_macro_i, target_empty_i,
    preset_write_i, factory_preset_i, preset_check_i, preset_failed_i,
    stored_illegal_i, writes_storage_i, storage_write_lock_i,
    storage_full_i, cmd_kind_i, set_enable_i, enable_value_i} = q;

  command_error_reporter u_command_error_reporter (.clock_i, .rst_b_i,
    .cmd_valid_i, .name_known_i, .syntax_ok_i, .changes_param_i,
    .param_locked_i, .unlock_req_i, .password_ok_i, .dsp_over_i,
    .exec_macro_i, .target_empty_i, .preset_write_i, .factory_preset_i,
    .preset_check_i, .preset_failed_i, .stored_illegal_i,
    .writes_storage_i, .storage_write_lock_i, .storage_full_i,
    .cmd_kind_i, .set_enable_i, .enable_value_i,
    .hw_handshake_fail_i(hw), .sw_handshake_fail_i(sw),
    .unit_id_conflict_i(uid), .char_ready_i, .report_enable_o,
    .cmd_accept_o, .cmd_reject_o, .error_code_o, .macro_session_o,
    .macro_count_o, .macro_discard_o, .char_valid_o, .char_o);

  host_serial_model u_host_serial_model (.clock_i, .rst_b_i,
    .slow_i(slow), .char_valid_i(char_valid_o), .char_i(char_o),
    .char_ready_o(char_ready_i), .msg_o(msg), .msg_count_o(msgs));

  // Free-running 25 MHz clock, 40 ns period.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // Priority order of the checks, judged from the host's own view.
  function automatic logic [9:0] exp_code(logic [21:0] c);
    logic ap;
    ap = c[4:2] == 3'd2;
    if (!c[21]) return 10'd1;
    if (!c[20]) return 10'd2;
    if (c[17] && !c[16]) return 10'd5;
    if (c[19] && c[18]) return 10'd4;
    if (c[12] && c[11]) return 10'd71;
    if (c[7] && c[6]) return 10'd75;
    if (ap && !sess) return 10'd77;
    if (c[8]) return 10'd74;
    if (ap && cnt == 256) return 10'd73;
    if (ap && c[5]) return 10'd76;
    if (c[15]) return 10'd60;
    if (c[14] && c[13]) return 10'd70;
    if (c[10] && c[9]) return 10'd72;
    return 10'd0;
  endfunction

  function automatic logic [71:0] exp_msg(logic [9:0] c);
    return {"ERROR#", 8'h30 + 8'(c / 100), 8'h30 + 8'(c / 10 % 10),
      8'h30 + 8'(c % 10)};
  endfunction

  task automatic chk(input string nm, input logic [71:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Eight quiet cycles mean the message and its wait cycle are over.
  task automatic wait_idle;
    int k, quiet;
    quiet = 0;
    for (k = 0; k < 400 && quiet < 8; k++) begin
      @(posedge clock_i);
      #1 quiet = (char_valid_o === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 8) begin
      err_count++;
      tally_and_finish;
    end
  endtask

  task automatic run(input logic [21:0] c);
    logic [9:0] e;
    int n0;
    e = exp_code(c);
    n0 = msgs;
    @(posedge clock_i);
    q <= c;
    cmd_valid_i <= 1'b1;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    #1 chk("reject", cmd_reject_o, e != 0);
    chk("accept", cmd_accept_o, e == 0);
    if (e != 0) chk("code", error_code_o, e);
    chk("discard", macro_discard_o, e == 10'd76);
    if (e == 0 && c[4:2] inside {3'd1, 3'd4})
      {sess, cnt, up} = {1'b1, 32'd0, up | c[4]};
    if (e == 0 && c[4:2] == 3'd2) cnt++;
    if (e == 0 && c[4:2] == 3'd3) {sess, cnt} = {up, 32'd0};
    if (e == 10'd76) {sess, cnt, up} = '0;
    if (e == 0 && c[1]) en = c[0];
    chk("enable", report_enable_o, en);
    chk("session", macro_session_o, sess);
    if (e != 0) begin
      wait_idle;
      chk("count", msgs, n0 + (en ? 1 : 0));
      if (en) chk("message", msg, exp_msg(e));
    end
  endtask

  initial begin
    {q, cmd_valid_i, hw, sw, uid, slow, rst_b_i} = '0;
    {err_count, checks_done, cnt, sess, up} = '0;
    en = 1'b1;
    void'($urandom(32'h1bf9));
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    #1 chk("enable", report_enable_o, 1'b1);
    foreach (masks[i]) begin
      slow = i[0];
      run(BASE ^ masks[i]);
    end
    $display("Test codes done");
    run(BASE ^ 22'h2);
    foreach (masks[i]) run(BASE ^ masks[i]);
    run(BASE ^ 22'h3);
    $display("Test disable done");
    run(BASE ^ 22'h10);
    repeat (256) run(BASE ^ 22'h1C);
    chk("macro", macro_count_o, 9'h100);
    run(BASE ^ 22'h1C);
    run(BASE ^ 22'h10);
    run(BASE ^ 22'h3C);
    chk("macro", macro_count_o, 9'h000);
    run(BASE ^ 22'h1C);
    run(BASE ^ 22'h04);
    run(BASE ^ 22'h1C);
    run(BASE ^ 22'h18);
    run(BASE ^ 22'h3C);
    $display("Test macro done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_i);
      {hw, sw, uid} <= 3'b100 >> i;
      repeat (i == 0 ? 6 : 1) @(posedge clock_i);
      {hw, sw, uid} <= 3'b000;
      wait_idle;
      chk("bus", error_code_o, 10'(78 + i));
      chk("bus", msg, exp_msg(10'(78 + i)));
    end
    $display("Test bus done");
    repeat (300) begin
      f = 22'($urandom & $urandom);
      f[21] = $urandom % 8 != 0;
      f[20] = $urandom % 8 != 0;
      f[16] = $urandom % 4 != 0;
      f[4:2] = 3'($urandom % 6);
      f[1] = $urandom % 16 == 0;
      f[0] = $urandom % 4 != 0;
      slow = 1'($urandom % 2);
      run(f);
    end
    $display("Test random done");
    tally_and_finish;
  end
endmodule // command_error_reporter_tb
